/* File: rtccal_regs.vh */
// rtccal_regs.vh: register map, reset values, field positions and counts of the
// calendar / trim / weekly alarm stage.
// assumes inclusion by bare name from the design files of this block.
`ifndef RTCCAL_REGS_VH
`define RTCCAL_REGS_VH

`define RTCCAL_ADDR_W        20
`define RTCCAL_A_WEEKDAY     20'hfff95
`define RTCCAL_A_MONTH       20'hfff97
`define RTCCAL_A_YEAR        20'hfff98
`define RTCCAL_A_TRIM        20'hfff99
`define RTCCAL_A_ALM_MIN     20'hfff9a
`define RTCCAL_A_ALM_HOUR    20'hfff9b
`define RTCCAL_A_ALM_WDAY    20'hfff9c

`define RTCCAL_RST_WEEKDAY   8'h00
`define RTCCAL_RST_MONTH     8'h01
`define RTCCAL_RST_YEAR      8'h00
`define RTCCAL_RST_TRIM      8'h00
`define RTCCAL_RST_ALM_MIN   8'h00
`define RTCCAL_RST_ALM_H12   8'h12
`define RTCCAL_RST_ALM_H24   8'h00
`define RTCCAL_RST_ALM_WDAY  8'h00

`define RTCCAL_WDAY_MAX      8'h06
`define RTCCAL_MONTH_MIN     8'h01
`define RTCCAL_MONTH_MAX     8'h12
`define RTCCAL_YEAR_MAX      8'h99
`define RTCCAL_DAY_MIN       8'h01
`define RTCCAL_MIN_MAX       8'h59

`define RTCCAL_TRIM_INTERVAL 7
`define RTCCAL_TRIM_SIGN     6
`define RTCCAL_AFTERNOON     5

`define RTCCAL_PRESC_REF     16'h7fff
`define RTCCAL_SEC_00        8'h00
`define RTCCAL_SEC_20        8'h20
`define RTCCAL_SEC_40        8'h40
`define RTCCAL_LAND_CYCLES   2'd2

`endif

/* File: rtccal_trim.v */
// rtccal_trim.v: sub-second prescaler with watch error correction.
// assumes seconds and trim value arrive on mclk from the calendar core.
`timescale 1ns/1ps
`include "rtccal_regs.vh"
module rtccal_trim #(
	parameter PW = 16
) (
	input  wire          mclk,
	input  wire          rst_n,
	input  wire          run,
	input  wire          clear,
	input  wire [7:0]    trim,
	input  wire [7:0]    seconds,
	output reg           sec_tick_q
);
	reg  [PW-1:0] presc_q;
	reg  [PW-1:0] term;
	wire [5:0]    mag = trim[5:0];
	wire          sec_hit;
	wire          trim_on;

	assign sec_hit = (seconds == `RTCCAL_SEC_00) ||
		(!trim[`RTCCAL_TRIM_INTERVAL] &&
		 (seconds == `RTCCAL_SEC_20 || seconds == `RTCCAL_SEC_40));
	assign trim_on = sec_hit && (mag[5:1] != 5'h00);

	always @* begin
		term = `RTCCAL_PRESC_REF;
		if (trim_on) begin
			if (!trim[`RTCCAL_TRIM_SIGN])
				term = `RTCCAL_PRESC_REF + {{(PW-7){1'b0}}, mag - 6'h01, 1'b0};
			else
				term = `RTCCAL_PRESC_REF - {{(PW-7){1'b0}}, ~mag + 6'h01, 1'b0};
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			presc_q    <= {PW{1'b0}};
			sec_tick_q <= 1'b0;
		end else begin
			sec_tick_q <= 1'b0;
			if (clear) begin
				presc_q <= {PW{1'b0}};
			end else if (run) begin
				if (presc_q >= term) begin
					presc_q    <= {PW{1'b0}};
					sec_tick_q <= 1'b1;
				end else begin
					presc_q <= presc_q + {{(PW-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // rtccal_trim

/* File: rtccal_alarm.v */
// rtccal_alarm.v: weekly alarm comparator.
// assumes current hour and minute come from the lower clock stage, weekday from the weekday counter.
`timescale 1ns/1ps
`include "rtccal_regs.vh"
module rtccal_alarm (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       alarm_enable,
	input  wire       hour_format_select,
	input  wire [7:0] cur_minute,
	input  wire [7:0] cur_hour,
	input  wire [2:0] cur_weekday,
	input  wire [7:0] alarm_minute,
	input  wire [7:0] alarm_hour,
	input  wire [7:0] alarm_weekday_mask,
	output reg        match_q
);
	function bcd_ok;
		input [7:0] v;
		input [7:0] lo;
		input [7:0] hi;
		begin
			bcd_ok = (v[3:0] <= 4'h9) && (v >= lo) && (v <= hi);
		end
	endfunction

	wire min_ok = bcd_ok(alarm_minute, 8'h00, `RTCCAL_MIN_MAX);
	// 24 h: 00..23; 12 h: 01..12 morning, 21..32 afternoon
	wire hr_ok  = hour_format_select ? bcd_ok(alarm_hour, 8'h00, 8'h23) :
		(bcd_ok(alarm_hour, 8'h01, 8'h12) || bcd_ok(alarm_hour, 8'h21, 8'h32));
	wire day_ok = alarm_weekday_mask[cur_weekday];
	wire hit    = alarm_enable && day_ok && min_ok && hr_ok &&
		(alarm_minute == cur_minute) && (alarm_hour == cur_hour);
	reg  hit_q;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hit_q   <= 1'b0;
			match_q <= 1'b0;
		end else begin
			hit_q   <= hit;
			match_q <= hit && !hit_q;
		end
	end
endmodule // rtccal_alarm

/* File: rtccal_top.v */
// rtccal_top.v: weekday/month/year counters, trim register and weekly alarm
// registers on an 8-bit memory port.
// assumes mclk is the count clock, lower counters live elsewhere and feed
// day_carry, day_count and the time inputs on mclk.
`timescale 1ns/1ps
`include "rtccal_regs.vh"
module rtccal_top (
	input  wire                      mclk,
	input  wire                      rst_n,
	input  wire [`RTCCAL_ADDR_W-1:0] addr,
	input  wire                      wr_en,
	input  wire                      rd_en,
	input  wire [7:0]                wdata,
	output reg  [7:0]                rdata_q,
	input  wire                      clock_run_enable,
	input  wire                      counter_hold_request,
	input  wire                      hour_format_select,
	input  wire                      alarm_enable,
	input  wire                      presc_clear,
	input  wire [7:0]                seconds_counter,
	input  wire [7:0]                cur_minute,
	input  wire [7:0]                cur_hour,
	input  wire                      day_carry,
	input  wire [7:0]                day_count,
	output reg  [7:0]                weekday_q,
	output reg  [7:0]                month_q,
	output reg  [7:0]                year_q,
	output reg                       feb_days29_q,
	output reg  [7:0]                day_max_q,
	output reg                       sec_tick_q,
	output reg                       alarm_match_q,
	output reg                       counter_hold_status_q
);
	reg  [7:0] trim_q;
	reg  [7:0] alm_min_q;
	reg  [7:0] alm_hour_q;
	reg  [7:0] alm_wday_q;
	reg        fmt_seen_q;
	reg  [7:0] buf_q      [0:2];
	reg  [2:0] pend_q;
	reg  [1:0] age_q;
	reg        month_wrap;
	reg        year_carry;
	reg  [7:0] dmax;
	wire       tick;
	wire       match;
	wire       wr_wk = wr_en && addr == `RTCCAL_A_WEEKDAY;
	wire       wr_mo = wr_en && addr == `RTCCAL_A_MONTH;
	wire       wr_yr = wr_en && addr == `RTCCAL_A_YEAR;
	wire       leap  = ~year_q[4] ? (year_q[1:0] == 2'b00) : (year_q[1:0] == 2'b10);

	function [7:0] bcd_inc;
		input [7:0] v;
		begin
			if (v[3:0] >= 4'h9)
				bcd_inc = {v[7:4] + 4'h1, 4'h0};
			else
				bcd_inc = v + 8'h01;
		end
	endfunction

	// days in the running month
	always @* begin
		case (month_q)
		8'h02:   dmax = leap ? 8'h29 : 8'h28;
		8'h04,
		8'h06,
		8'h09,
		8'h11:   dmax = 8'h30;
		default: dmax = 8'h31;
		endcase
	end

	always @* begin
		month_wrap = day_carry && (month_q == `RTCCAL_MONTH_MAX);
		year_carry = month_wrap;
	end

	// weekday, month and year writes are held one cycle in a buffer, then land on the counter
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			buf_q[0] <= 8'h00;
			buf_q[1] <= 8'h00;
			buf_q[2] <= 8'h00;
			pend_q   <= 3'b000;
			age_q    <= 2'd0;
		end else begin
			if (wr_wk)
				buf_q[0] <= {5'h00, wdata[2:0]};
			if (wr_mo)
				buf_q[1] <= {3'h0, wdata[4:0]};
			if (wr_yr)
				buf_q[2] <= wdata;
			pend_q <= {wr_yr, wr_mo, wr_wk};
			age_q  <= (wr_wk || wr_mo || wr_yr) ? 2'd1 : 2'd0;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			weekday_q <= `RTCCAL_RST_WEEKDAY;
			month_q   <= `RTCCAL_RST_MONTH;
			year_q    <= `RTCCAL_RST_YEAR;
		end else begin
			if (pend_q[0])
				weekday_q <= buf_q[0];
			else if (day_carry)
				weekday_q <= (weekday_q >= `RTCCAL_WDAY_MAX) ? 8'h00 :
					weekday_q + 8'h01;
			if (pend_q[1] || wr_mo)
				month_q <= pend_q[1] ? buf_q[1] : month_q;
			else if (day_carry)
				month_q <= month_wrap ? `RTCCAL_MONTH_MIN : bcd_inc(month_q);
			if (pend_q[2] || wr_yr)
				year_q <= pend_q[2] ? buf_q[2] : year_q;
			else if (year_carry)
				year_q <= (year_q == `RTCCAL_YEAR_MAX) ? 8'h00 : bcd_inc(year_q);
		end
	end

	// control and trim / alarm registers
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			trim_q      <= `RTCCAL_RST_TRIM;
			alm_min_q   <= `RTCCAL_RST_ALM_MIN;
			alm_hour_q  <= `RTCCAL_RST_ALM_H12;
			alm_wday_q  <= `RTCCAL_RST_ALM_WDAY;
			fmt_seen_q  <= 1'b0;
		end else begin
			fmt_seen_q <= fmt_seen_q || hour_format_select;
			if (hour_format_select && !fmt_seen_q &&
			    !(wr_en && addr == `RTCCAL_A_ALM_HOUR))
				alm_hour_q <= `RTCCAL_RST_ALM_H24;
			if (wr_en) begin
				case (addr)
				`RTCCAL_A_TRIM:     trim_q     <= wdata;
				`RTCCAL_A_ALM_MIN:  alm_min_q  <= {1'b0, wdata[6:0]};
				`RTCCAL_A_ALM_HOUR: alm_hour_q <= {2'b00, wdata[5:0]};
				`RTCCAL_A_ALM_WDAY: alm_wday_q <= {1'b0, wdata[6:0]};
				default: ;
				endcase
			end
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q               <= 8'h00;
			counter_hold_status_q <= 1'b0;
			feb_days29_q          <= 1'b0;
			day_max_q             <= 8'h31;
			sec_tick_q            <= 1'b0;
			alarm_match_q         <= 1'b0;
		end else begin
			counter_hold_status_q <= counter_hold_request;
			feb_days29_q          <= leap;
			day_max_q             <= dmax;
			sec_tick_q            <= tick;
			alarm_match_q         <= match;
			if (rd_en) begin
				case (addr)
				`RTCCAL_A_WEEKDAY:  rdata_q <= weekday_q;
				`RTCCAL_A_MONTH:    rdata_q <= month_q;
				`RTCCAL_A_YEAR:     rdata_q <= year_q;
				`RTCCAL_A_TRIM:     rdata_q <= trim_q;
				`RTCCAL_A_ALM_MIN:  rdata_q <= alm_min_q;
				`RTCCAL_A_ALM_HOUR: rdata_q <= alm_hour_q;
				`RTCCAL_A_ALM_WDAY: rdata_q <= alm_wday_q;
				default:            rdata_q <= 8'h00;
				endcase
			end
		end
	end

	rtccal_trim #(
		.PW(16)
	) u_trim (
		.mclk       (mclk),
		.rst_n      (rst_n),
		.run        (clock_run_enable),
		.clear      (presc_clear),
		.trim       (trim_q),
		.seconds    (seconds_counter),
		.sec_tick_q (tick)
	);

	rtccal_alarm u_alarm (
		.mclk               (mclk),
		.rst_n              (rst_n),
		.alarm_enable       (alarm_enable),
		.hour_format_select (hour_format_select),
		.cur_minute         (cur_minute),
		.cur_hour           (cur_hour),
		.cur_weekday        (weekday_q[2:0]),
		.alarm_minute       (alm_min_q),
		.alarm_hour         (alm_hour_q),
		.alarm_weekday_mask (alm_wday_q),
		.match_q            (match)
	);
endmodule // rtccal_top

/* File: rtccal_chk_sva.sv */
// rtccal_chk_sva.sv: port checker for the calendar, trim and alarm stage.
// assumes it is bound to rtccal_top, all logic on mclk.
`timescale 1ns/1ps
`include "rtccal_regs.vh"
module rtccal_chk (
	input wire                      mclk,
	input wire                      rst_n,
	input wire [`RTCCAL_ADDR_W-1:0] addr,
	input wire                      wr_en,
	input wire                      rd_en,
	input wire [7:0]                wdata,
	input wire [7:0]                rdata_q,
	input wire                      day_carry,
	input wire                      alarm_enable,
	input wire [7:0]                weekday_q,
	input wire [7:0]                month_q,
	input wire [7:0]                year_q,
	input wire                      feb_days29_q,
	input wire                      sec_tick_q,
	input wire                      alarm_match_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wday_range_a: assert property (weekday_q <= 8'h06)
		else $error("weekday out of range");
	wday_step_a: assert property (day_carry && !wr_en && !$past(wr_en) && weekday_q < 8'h06
		|=> weekday_q == $past(weekday_q) + 8'h01) else $error("weekday did not step");
	month_range_a: assert property (month_q >= 8'h01 && month_q <= 8'h12)
		else $error("month out of range");
	cal_wrap_a: assert property (day_carry && !wr_en && !$past(wr_en) && weekday_q == 8'h06
		&& month_q == 8'h12 && year_q == 8'h99
		|=> weekday_q == 8'h00 && month_q == 8'h01 && year_q == 8'h00) else $error("no wrap");
	month_land_a: assert property (wr_en && addr == `RTCCAL_A_MONTH
		|-> ##2 month_q == ($past(wdata, 2) & 8'h1f)) else $error("month write lost");
	year_keep_a: assert property (wr_en && addr == `RTCCAL_A_YEAR && day_carry
		|-> ##2 year_q == $past(wdata, 2)) else $error("year write lost to carry");
	leap_set_a: assert property (year_q[1:0] == {year_q[4], 1'b0} |=> feb_days29_q)
		else $error("leap year missed");
	leap_clr_a: assert property (year_q[1:0] != {year_q[4], 1'b0} |=> !feb_days29_q)
		else $error("normal year taken as leap");
	month_read_a: assert property (rd_en && addr == `RTCCAL_A_MONTH
		|=> rdata_q == $past(month_q)) else $error("month read wrong");
	tick_pulse_a: assert property (sec_tick_q |=> !sec_tick_q)
		else $error("seconds carry too long");
	alarm_off_a: assert property (!alarm_enable [*3] |-> !alarm_match_q)
		else $error("alarm while disabled");
	alarm_pulse_a: assert property (alarm_match_q |=> !alarm_match_q)
		else $error("alarm pulse too long");
	cover property (day_carry && month_q == 8'h12);
	cover property (alarm_match_q);
	cover property (sec_tick_q);
endmodule // rtccal_chk

bind rtccal_top rtccal_chk u_chk (.mclk, .rst_n, .addr, .wr_en, .rd_en, .wdata, .rdata_q,
	.day_carry, .alarm_enable, .weekday_q, .month_q, .year_q, .feb_days29_q,
	.sec_tick_q, .alarm_match_q);

/* File: tb_top.sv */
// tb_top.sv: register level test of rtccal_top.
// assumes the bench plays the lower clock stage and the byte bus master.
`timescale 1ns/1ps
`include "rtccal_regs.vh"
module tb_top;
	reg         mclk = 1'b0;
	reg         rst_n = 1'b0;
	reg  [19:0] addr = 20'h00000;
	reg         wr_en = 1'b0;
	reg         rd_en = 1'b0;
	reg  [7:0]  wdata = 8'h00;
	reg         run = 1'b0;
	reg         h24 = 1'b0;
	reg         alm_en = 1'b0;
	reg         pclr = 1'b0;
	reg  [7:0]  secs = 8'h05;
	reg  [7:0]  cmin = 8'h00;
	reg         dcar = 1'b0;
	reg         hold = 1'b0;
	wire        hold_st;
	wire [7:0]  rdata_q, weekday_q, month_q, year_q, day_max_q;
	wire        feb_days29_q, sec_tick_q, alarm_match_q;
	integer     errors = 0;
	integer     n_checks = 0;
	integer     cyc = 0;
	integer     i;

	rtccal_top uut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
		.wdata(wdata), .rdata_q(rdata_q), .clock_run_enable(run),
		.counter_hold_request(hold), .hour_format_select(h24), .alarm_enable(alm_en),
		.presc_clear(pclr), .seconds_counter(secs), .cur_minute(cmin), .cur_hour(8'h32),
		.day_carry(dcar), .day_count(8'h01), .weekday_q(weekday_q), .month_q(month_q),
		.year_q(year_q), .feb_days29_q(feb_days29_q), .day_max_q(day_max_q),
		.sec_tick_q(sec_tick_q), .alarm_match_q(alarm_match_q),
		.counter_hold_status_q(hold_st));

	always #4 mclk = ~mclk;

	task give_verdict;
		begin
			$display("checks %0d errors %0d", n_checks, errors);
			if (errors == 0 && n_checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask

	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (cyc == 70000) begin
			errors = errors + 1;
			give_verdict;
		end
	end

	task chk(input [63:0] what, input [15:0] got, input [15:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("wrong value %0s expected %h seen %h", what, exp, got);
			end
		end
	endtask

	task wr(input [19:0] a, input [7:0] d);
		begin
			@(posedge mclk);
			addr <= a;
			wdata <= d;
			wr_en <= 1'b1;
			@(posedge mclk);
			wr_en <= 1'b0;
		end
	endtask

	task rd(input [19:0] a, input [7:0] e);
		begin
			@(posedge mclk);
			addr <= a;
			rd_en <= 1'b1;
			@(posedge mclk);
			rd_en <= 1'b0;
			#1;
			chk("read", {8'h00, rdata_q}, {8'h00, e});
		end
	endtask

	task wrrd(input [19:0] a, input [7:0] d, input [7:0] e);
		begin
			wr(a, d);
			rd(a, e);
			repeat (2) @(posedge mclk);
			#1;
		end
	endtask

	// a new minute value makes the compare condition rise again
	task alarm_seen(input [7:0] m, input e);
		reg hit;
		begin
			hit = 1'b0;
			@(posedge mclk);
			cmin <= m;
			repeat (8) begin
				@(posedge mclk);
				#1;
				if (alarm_match_q === 1'b1)
					hit = 1'b1;
			end
			chk("alarm", {15'h0000, hit}, {15'h0000, e});
		end
	endtask

	task tick_gap(output integer n);
		begin
			n = 0;
			do begin
				@(posedge mclk);
				#1;
				n = n + 1;
			end while (sec_tick_q !== 1'b1 && n < 40000);
		end
	endtask

	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		for (i = 0; i < 9; i = i + 1)
			rd(`RTCCAL_A_WEEKDAY + i, (i == 2) ? 8'h01 : (i == 6) ? 8'h12 : 8'h00);
		chk("leap", {15'h0000, feb_days29_q}, 16'h0001);
		chk("daymax", {8'h00, day_max_q}, 16'h0031);
		chk("hold", {15'h0000, hold_st}, 16'h0000);
		@(posedge mclk);
		h24 <= 1'b1;
		rd(`RTCCAL_A_ALM_HOUR, `RTCCAL_RST_ALM_H24);
		@(posedge mclk);
		h24 <= 1'b0;
		hold <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		chk("hold", {15'h0000, hold_st}, 16'h0001);
		wrrd(`RTCCAL_A_ALM_MIN, 8'hff, 8'h7f);
		wrrd(`RTCCAL_A_ALM_HOUR, 8'hff, 8'h3f);
		wrrd(`RTCCAL_A_ALM_WDAY, 8'hff, 8'h7f);
		wrrd(`RTCCAL_A_TRIM, 8'ha5, 8'ha5);
		wrrd(`RTCCAL_A_WEEKDAY, 8'h06, 8'h06);
		wrrd(`RTCCAL_A_MONTH, 8'h12, 8'h12);
		wrrd(`RTCCAL_A_YEAR, 8'h99, 8'h99);
		@(posedge mclk);
		dcar <= 1'b1;
		@(posedge mclk);
		dcar <= 1'b0;
		#1;
		chk("weekday", {8'h00, weekday_q}, 16'h0000);
		chk("month", {8'h00, month_q}, 16'h0001);
		chk("year", {8'h00, year_q}, 16'h0000);
		wrrd(`RTCCAL_A_MONTH, 8'h12, 8'h12);
		@(posedge mclk);
		addr <= `RTCCAL_A_YEAR;
		wdata <= 8'h45;
		wr_en <= 1'b1;
		dcar <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
		dcar <= 1'b0;
		rd(`RTCCAL_A_YEAR, 8'h45);
		wrrd(`RTCCAL_A_YEAR, 8'h96, 8'h96);
		wrrd(`RTCCAL_A_MONTH, 8'h02, 8'h02);
		chk("leap", {15'h0000, feb_days29_q}, 16'h0001);
		chk("daymax", {8'h00, day_max_q}, 16'h0029);
		wrrd(`RTCCAL_A_YEAR, 8'h98, 8'h98);
		chk("leap", {15'h0000, feb_days29_q}, 16'h0000);
		chk("daymax", {8'h00, day_max_q}, 16'h0028);
		wrrd(`RTCCAL_A_MONTH, 8'h04, 8'h04);
		chk("daymax", {8'h00, day_max_q}, 16'h0030);
		wrrd(`RTCCAL_A_WEEKDAY, 8'h01, 8'h01);
		wr(`RTCCAL_A_ALM_HOUR, 8'h32);
		wr(`RTCCAL_A_ALM_WDAY, 8'h02);
		wr(`RTCCAL_A_ALM_MIN, 8'h59);
		@(posedge mclk);
		alm_en <= 1'b1;
		alarm_seen(8'h59, 1'b1);
		wr(`RTCCAL_A_ALM_MIN, 8'h60);
		alarm_seen(8'h60, 1'b0);
		wr(`RTCCAL_A_ALM_WDAY, 8'h01);
		wr(`RTCCAL_A_ALM_MIN, 8'h59);
		alarm_seen(8'h59, 1'b0);
		wr(`RTCCAL_A_TRIM, 8'h7c);
		@(posedge mclk);
		secs <= 8'h00;
		run <= 1'b1;
		pclr <= 1'b1;
		@(posedge mclk);
		pclr <= 1'b0;
		tick_gap(i);
		tick_gap(i);
		chk("period", i[15:0], 16'h7ff8);
		give_verdict;
	end
endmodule // tb_top
